// *** include/lsc_consts.svh ***
// Offsets, field positions, reset values and timing counts of the load switch registers
`ifndef LSC_CONSTS_SVH
`define LSC_CONSTS_SVH
`define LSC_SW4_CTRL_IDX   8'h12
`define LSC_SW5_CTRL_IDX   8'h13
`define LSC_IRQ_STAT_IDX   8'h20
`define LSC_IRQ_MASK_IDX   8'h21
`define LSC_ADDR_W         10
`define LSC_BIT_ON         0
`define LSC_BIT_DIS        1
`define LSC_BIT_WAIT_LO    2
`define LSC_BIT_WAIT_HI    3
`define LSC_BIT_PG         4
`define LSC_BIT_OT         5
`define LSC_BIT_OC         6
`define LSC_BIT_TO         7
`define LSC_CTRL_RST       8'h02
`define LSC_CLK_MHZ        10
`define LSC_WAIT0_US       200
`define LSC_WAIT1_US       800
`define LSC_WAIT2_US       1600
`define LSC_WAIT3_US       3200
`define LSC_WAIT0_CYC      (`LSC_WAIT0_US * `LSC_CLK_MHZ)
`define LSC_WAIT1_CYC      (`LSC_WAIT1_US * `LSC_CLK_MHZ)
`define LSC_WAIT2_CYC      (`LSC_WAIT2_US * `LSC_CLK_MHZ)
`define LSC_WAIT3_CYC      (`LSC_WAIT3_US * `LSC_CLK_MHZ)
`endif

// *** include/lsc_pkg.sv ***
// Types shared by the load switch control register bank
package lsc_pkg;
  typedef struct packed {
    logic       on;
    logic       discharge_on;
    logic [1:0] limit_wait_sel;
  } lsc_ctrl_t;
  typedef struct packed {
    logic overcurrent;
    logic overtemp;
    logic power_good;
    logic current_limited;
  } lsc_mon_t;
endpackage : lsc_pkg

// *** sim/lsc_regs_asserts.sv ***
// Checker for the load switch register bank
`include "lsc_consts.svh"
module lsc_regs_asserts
  import lsc_pkg::*;
#(parameter int NSW = 2) (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [`LSC_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]             wb_sel_i,
  input wire logic [31:0]            wb_dat_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  input wire lsc_ctrl_t [NSW-1:0]    ctrl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence take_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence wr4_s; take_s ##0 wb_we_i && wb_sel_i[0] && wb_adr_i == 10'h048; endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_answer_a: assert property (take_s |=> wb_ack_o) else $error("no ack");
  reset_ctrl_a: assert property ($fell(rst_i) |-> ctrl_o == {NSW{4'h4}})
    else $error("rst");
  write_on_a: assert property (wr4_s |=> ctrl_o[0][3:2] == {$past(wb_dat_i[0]),
    $past(wb_dat_i[1])}) else $error("on bits");
  write_wait_a: assert property (wr4_s |=> ctrl_o[0].limit_wait_sel == $past(wb_dat_i[3:2]))
    else $error("wait bits");
  hold_ctrl_a: assert property (!(wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0])
    |=> $stable(ctrl_o)) else $error("ctrl moved");
  read_ctrl_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 10'h048 |-> wb_dat_o[3:0]
    == {ctrl_o[0][1:0], ctrl_o[0][2], ctrl_o[0][3]}) else $error("read ctrl");
  idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("idle data");
endmodule : lsc_regs_asserts
bind lsc_regs lsc_regs_asserts #(.NSW(NSW)) u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ctrl_o);

// *** sim/tb_top.sv ***
// Self-checking bench of the load switch register bank
module tb_top
  import lsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int W[4] = '{8, 16, 24, 32};
  logic            clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [9:0]      wb_adr_i = 10'h0;
  logic [3:0]      wb_sel_i = 4'h0;
  logic [31:0]     wb_dat_i = 32'h0, wb_dat_o, rd;
  logic            wb_ack_o, irq_o;
  lsc_mon_t [1:0]  mon_i = '0;
  lsc_ctrl_t [1:0] ctrl_o;
  int              n_mismatch = 0, n_compared = 0, cycles = 0;
  // Rows: address, write byte, byte read back
  logic [9:0]      r_adr[5] = '{10'h048, 10'h04c, 10'h048, 10'h090, 10'h084};
  logic [7:0]      r_wd[5] = '{8'hff, 8'hf9, 8'h00, 8'hff, 8'h0f};
  logic [7:0]      r_exp[5] = '{8'h0f, 8'h09, 8'h0f, 8'h00, 8'h0f};
  // Short waits keep the time-out runs brief
  lsc_regs #(.WAIT0_CYC(8), .WAIT1_CYC(16), .WAIT2_CYC(24), .WAIT3_CYC(32)) uut (.clk_i,
    .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .mon_i, .ctrl_o, .irq_o);
  always #50 clk_i = ~clk_i;
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Request held until ack is sampled high at a rising edge, released there
  task automatic bus(logic [9:0] a, logic w, logic [31:0] d, logic [3:0] s);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, s};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : bus
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(10'h048, 1'b0, 32'h0, 4'h1);
    check("sw4 reset", rd, 32'h02);
    check("sw5 port", {28'h0, ctrl_o[1]}, 32'h4);
    for (int i = 0; i < 5; i++) begin
      bus(r_adr[i], 1'b1, {24'hffffff, r_wd[i]}, (i == 2) ? 4'h0 : 4'h1);
      bus(r_adr[i], 1'b0, 32'h0, 4'h1);
      check("row", rd, {24'h0, r_exp[i]});
    end
    mon_i[0] <= 4'he;
    bus(10'h048, 1'b0, 32'h0, 4'h1);
    check("flags", rd, 32'h7f);
    repeat (2) @(negedge clk_i);
    check("irq up", {31'h0, irq_o}, 32'h1);
    bus(10'h084, 1'b1, 32'h0, 4'h1);
    repeat (2) @(negedge clk_i);
    check("irq masked", {31'h0, irq_o}, 32'h0);
    bus(10'h080, 1'b1, 32'hf, 4'h1);
    bus(10'h084, 1'b1, 32'hf, 4'h1);
    repeat (2) @(negedge clk_i);
    check("irq cleared", {31'h0, irq_o}, 32'h0);
    for (int k = 0; k < 4; k++) begin
      bus(10'h048, 1'b1, {28'h0, k[1:0], 2'b01}, 4'h1);
      mon_i[0] <= 4'h1;
      repeat (W[k] - 4) @(posedge clk_i);
      bus(10'h048, 1'b0, 32'h0, 4'h1);
      check("early", rd, {28'h0, k[1:0], 2'b01});
      repeat (6) @(posedge clk_i);
      bus(10'h048, 1'b0, 32'h0, 4'h1);
      check("timeout", rd, {24'h0, 4'h8, k[1:0], 2'b01});
      check("irq timeout", {31'h0, irq_o}, 32'h1);
      mon_i[0] <= 4'h0;
      bus(10'h048, 1'b1, 32'h0, 4'h1);
      bus(10'h080, 1'b1, 32'hff, 4'h1);
    end
    // Reset in mid-run must bring the control bits back
    bus(10'h04c, 1'b1, 32'h1, 4'h1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(10'h04c, 1'b0, 32'h0, 4'h1);
    check("sw5 rerst", rd, 32'h02);
    summarize();
  end
endmodule : tb_top

// *** src/lsc_regs.sv ***
// Control and status registers of load switches four and five, Wishbone slave
// Function
// [RQ1] Bit 0 switches the load switch on; read/write, resets to zero.
// [RQ2] Bit 1 enables output auto-discharge; read/write, resets to one.
// [RQ3] Bits 3:2 pick time-out wait 200, 800, 1600 or 3200 us.
// [RQ4] Bit 7 reads one after a current-limit time-out; resets to zero.
// [RQ5] Bit 6 reads one when overcurrent is detected; resets to zero.
// [RQ6] Bit 5 reads one when overtemperature is detected; resets to zero.
// [RQ7] Bit 4 reads one while output is power good; resets to zero. The code also needs bit 0 set: bit 4 reads zero while the switch is off.
// [RQ8] Writes to the four status bits are ignored.
`include "lsc_consts.svh"
module lsc_regs
  import lsc_pkg::*;
#(
  parameter int WAIT0_CYC = `LSC_WAIT0_CYC,
  parameter int WAIT1_CYC = `LSC_WAIT1_CYC,
  parameter int WAIT2_CYC = `LSC_WAIT2_CYC,
  parameter int WAIT3_CYC = `LSC_WAIT3_CYC,
  parameter int NSW       = 2
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [`LSC_ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire lsc_mon_t [NSW-1:0]     mon_i,
  output lsc_ctrl_t [NSW-1:0]         ctrl_o,
  output logic                        irq_o
);
  localparam int EVW = 4 * NSW;

  function automatic logic [15:0] wait_cycles(input logic [1:0] sel);
    unique case (sel)
      2'h0: wait_cycles = 16'(WAIT0_CYC);
      2'h1: wait_cycles = 16'(WAIT1_CYC);
      2'h2: wait_cycles = 16'(WAIT2_CYC);
      2'h3: wait_cycles = 16'(WAIT3_CYC);
    endcase
  endfunction : wait_cycles

  // Every register is eight bits in the low byte; upper bits read zero
  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h000000, b};
  endfunction : byte_word

  localparam logic [7:0] CTRL_RST = `LSC_CTRL_RST;

  // Per-switch state is unpacked so each generate copy owns its own words
  logic                on_q      [NSW];
  logic                dis_q     [NSW];
  logic [1:0]          wsel_q    [NSW];
  logic                to_q      [NSW];
  logic                oc_q      [NSW];
  logic                ot_q      [NSW];
  logic                pg_q      [NSW];
  logic [15:0]         lim_cnt_q [NSW];

  // Interrupt status, mask and edge memory
  logic [EVW-1:0]      stat_q;
  logic [EVW-1:0]      mask_q;
  logic [EVW-1:0]      ev_prev_q;

  // Bus answer and interrupt output registers
  logic                ack_q;
  logic [31:0]         rdat_q;
  logic                irq_q;

  // Bus decode
  wire logic           req;
  wire logic           wr_lo;
  wire logic [7:0]     word_idx;
  wire logic           hit_sw4;
  wire logic           hit_sw5;
  wire logic           hit_stat;
  wire logic           hit_mask;
  wire logic [NSW-1:0] hit_sw;

  // Event, read and control paths
  wire logic [EVW-1:0] ev_now;
  wire logic [EVW-1:0] ev_rise;
  wire logic [EVW-1:0] clr_mask;
  wire logic [EVW-1:0] stat_d;
  wire logic [EVW-1:0] irq_src;
  wire logic [7:0]     reg_sw [NSW];
  wire logic [31:0]    rd_mux;
  wire logic [31:0]    rdat_d;
  wire lsc_ctrl_t [NSW-1:0] ctrl_w;

  // A second request is only taken after ack has dropped
  assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_lo    = req & wb_we_i & wb_sel_i[0];
  assign word_idx = wb_adr_i[`LSC_ADDR_W-1:2];
  assign hit_sw4  = word_idx == `LSC_SW4_CTRL_IDX;
  assign hit_sw5  = word_idx == `LSC_SW5_CTRL_IDX;
  assign hit_stat = word_idx == `LSC_IRQ_STAT_IDX;
  assign hit_mask = word_idx == `LSC_IRQ_MASK_IDX;
  assign hit_sw   = {hit_sw5, hit_sw4};
  assign ev_rise  = ev_now & ~ev_prev_q;

  genvar g;
  generate
    for (g = 0; g < NSW; g++) begin : g_sw
      wire logic        wr_ctrl;
      wire logic        on_d;
      wire logic        dis_d;
      wire logic [1:0]  wsel_d;
      wire logic        limiting;
      wire logic [15:0] limit;
      wire logic        at_limit;
      wire logic        expire;
      wire logic [15:0] cnt_d;
      wire logic        to_d;
      wire logic        oc_d;
      wire logic        ot_d;
      wire logic        pg_d;

      // Only the low four bits store; status bits are not writable
      assign wr_ctrl = wr_lo & hit_sw[g]; // see [RQ8]
      assign on_d    = wr_ctrl ? wb_dat_i[`LSC_BIT_ON] : on_q[g]; // see [RQ1]
      assign dis_d   = wr_ctrl ? wb_dat_i[`LSC_BIT_DIS] : dis_q[g]; // see [RQ2]
      assign wsel_d  = wr_ctrl ? wb_dat_i[`LSC_BIT_WAIT_HI:`LSC_BIT_WAIT_LO]
                               : wsel_q[g]; // see [RQ3]

      // Wait time counts only while the switch sits in current limit
      assign limiting = on_q[g] & mon_i[g].current_limited;
      assign limit    = wait_cycles(wsel_q[g]);
      assign at_limit = lim_cnt_q[g] >= limit - 16'h0001;
      assign expire   = limiting & at_limit;
      // Counter parks at limit minus one so it cannot wrap during a long overload
      assign cnt_d    = !limiting ? 16'h0000 :
                        expire    ? lim_cnt_q[g] :
                                    lim_cnt_q[g] + 16'h0001; // see [RQ3]

      // Time-out holds until the switch is turned off; setting wins
      assign to_d = expire | (to_q[g] & on_q[g]); // see [RQ4]
      assign oc_d = mon_i[g].overcurrent; // see [RQ5]
      assign ot_d = mon_i[g].overtemp; // see [RQ6]
      // Power good only means something while the switch conducts
      assign pg_d = on_q[g] & mon_i[g].power_good; // see [RQ7]

      // Read word and event vector of this switch
      assign reg_sw[g] = {to_q[g], oc_q[g], ot_q[g], pg_q[g],
                          wsel_q[g], dis_q[g], on_q[g]};
      assign ev_now[4*g +: 4] = {to_q[g], oc_q[g], ot_q[g], pg_q[g]};
      assign ctrl_w[g] = {on_q[g], dis_q[g], wsel_q[g]}; // see [RQ1] see [RQ2]

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          on_q[g]   <= CTRL_RST[`LSC_BIT_ON]; // see [RQ1]
          dis_q[g]  <= CTRL_RST[`LSC_BIT_DIS]; // see [RQ2]
          wsel_q[g] <= CTRL_RST[`LSC_BIT_WAIT_HI:`LSC_BIT_WAIT_LO];
        end else begin
          on_q[g]   <= on_d;
          dis_q[g]  <= dis_d;
          wsel_q[g] <= wsel_d;
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          lim_cnt_q[g] <= 16'h0000;
        end else begin
          lim_cnt_q[g] <= cnt_d;
        end
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          to_q[g] <= 1'b0; // see [RQ4]
          oc_q[g] <= 1'b0; // see [RQ5]
          ot_q[g] <= 1'b0; // see [RQ6]
          pg_q[g] <= 1'b0; // see [RQ7]
        end else begin
          to_q[g] <= to_d;
          oc_q[g] <= oc_d;
          ot_q[g] <= ot_d;
          pg_q[g] <= pg_d;
        end
      end
    end
  endgenerate

  // Set wins over a write-one clear in the same cycle
  assign clr_mask = (wr_lo & hit_stat) ? wb_dat_i[EVW-1:0] : '0;
  assign stat_d   = (stat_q & ~clr_mask) | ev_rise;
  assign irq_src  = stat_d & mask_q;

  assign rd_mux = hit_sw4  ? byte_word(reg_sw[0]) :
                  hit_sw5  ? byte_word(reg_sw[1]) :
                  hit_stat ? byte_word(8'(stat_q)) :
                  hit_mask ? byte_word(8'(mask_q)) : 32'h00000000;
  // Data is zero outside the ack cycle so stale data is never seen
  assign rdat_d = req ? rd_mux : 32'h00000000;

  // Edge memory starts low: flags are low in reset, so no false event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_prev_q <= '0;
    end else begin
      ev_prev_q <= ev_now;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= '0;
    end else if (wr_lo & hit_mask) begin
      mask_q <= wb_dat_i[EVW-1:0];
    end
  end

  // One wait state: every request is answered in the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h00000000;
    end else begin
      rdat_q <= rdat_d;
    end
  end

  // Registered so the pin never glitches while status and mask settle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |irq_src;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign irq_o    = irq_q;
  assign ctrl_o   = ctrl_w;
endmodule : lsc_regs
